// file: ofs_defs.svh
// constants for the output function sequencer: offsets, fields, resets, timing
`ifndef OFS_DEFS_SVH
`define OFS_DEFS_SVH
// ----------
// register byte offsets (word aligned)
// ----------
`define OFS_A_RELAY_FUNC   8'h00
`define OFS_A_OC_FUNC      8'h04
`define OFS_A_TMR_ON       8'h08
`define OFS_A_TMR_OFF      8'h0C
`define OFS_A_BRK_EN       8'h10
`define OFS_A_REL_CURR     8'h14
`define OFS_A_REL_HOLD     8'h18
`define OFS_A_REL_FWD      8'h1C
`define OFS_A_REL_REV      8'h20
`define OFS_A_ENG_HOLD     8'h24
`define OFS_A_ENG_FREQ     8'h28
`define OFS_A_DC_TIME      8'h2C
`define OFS_A_DC_LEVEL     8'h30
`define OFS_A_CMP_SRC      8'h34
`define OFS_A_CMP_ON       8'h38
`define OFS_A_CMP_OFF      8'h3C
`define OFS_A_STATUS       8'h40
`define OFS_A_IN_FUNC0     8'h60
// ----------
// function codes and reset values
// ----------
`define OFS_FN_TIMER_IN    6'h26
`define OFS_FN_TIMER_OUT   6'h1C
`define OFS_FN_ONOFF       6'h22
`define OFS_FN_BRAKE       6'h23
`define OFS_RST_TMR_ON     16'h012C
`define OFS_RST_TMR_OFF    16'h0064
`define OFS_RST_REL_CURR   16'h01F4
`define OFS_RST_REL_HOLD   16'h0064
`define OFS_RST_REL_FREQ   16'h0064
`define OFS_RST_ENG_HOLD   16'h0064
`define OFS_RST_ENG_FREQ   16'h00C8
`define OFS_RST_CMP_SRC    2'h1
`define OFS_RST_CMP_ON     16'h2328
`define OFS_RST_CMP_OFF    16'h03E8
`define OFS_FULL_SCALE     16'h2710
// ----------
// timing: delays count in 10 ms ticks
// ----------
`define OFS_CLK_HZ         20000000
`define OFS_TICK_MS        10
`define OFS_TICK_CYCLES    ((`OFS_CLK_HZ / 1000) * `OFS_TICK_MS)
`endif

// file: ofs_motor_model.sv
// behavioural motor core with load current, the sequencer's far side
`timescale 1ns/1ps
`default_nettype none

module ofs_motor_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire logic [15:0] freq_target_i,
  input  wire logic        freq_limit_i,
  input  wire logic        freq_hold_i,
  input  wire logic        freq_zero_i,
  input  wire logic [15:0] load_i,
  output logic      [15:0] out_freq_o,
  output logic      [15:0] current_o
);
  // ----------
  // ramp
  // ----------
  logic [15:0] ceil_w;
  // release frequency caps the ramp while limited, else a fixed top speed
  assign ceil_w = freq_limit_i ? freq_target_i : 16'h03E8;
  // one 0.10 Hz step a clock; coarse, so the engage crossing overshoots by one step, the release crossing stops at the cap
  always_ff @(posedge clk_i)
  begin
    if (rst_i || freq_zero_i)
      out_freq_o <= 16'h0000;
    else if (freq_hold_i)
      out_freq_o <= out_freq_o;
    else if (run_i)
      out_freq_o <= (out_freq_o + 16'h000A > ceil_w) ? ceil_w : out_freq_o + 16'h000A;
    else
      out_freq_o <= (out_freq_o > 16'h000A) ? out_freq_o - 16'h000A : 16'h0000;
  end
  // current flows only while the shaft turns
  assign current_o = (out_freq_o != 16'h0000) ? load_i : 16'h0000;
endmodule : ofs_motor_model
`default_nettype wire

// file: ofs_output_function_sequencer.sv
// output function sequencer: timer, brake sequencer, analog comparator, output select
//
// How it works
// - a terminal whose function code is 38 feeds the timer trigger
// - an output with function code 28 follows the timer result
// - timer output turns on only after the full on-delay elapses
// - timer output turns off only after the full off-delay elapses
// - brake control enabled suppresses start DC braking and dwell
// - run from stop ramps to release frequency of commanded direction
// - at release frequency, release brake once current reaches release level
// - after release, hold frequency for release delay, then accelerate
// - on stop, decelerate; at engage frequency hold and engage brake
// - after engage, hold frequency for engage delay, then force zero
// - with DC time and level set, DC brake then block output
// - configuration selects comparator analog input; voltage input by default
// - on level kept between off level and full scale, off at or below on
//
// Decided for this implementation: register access over Wishbone and the address map.
`include "ofs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ofs_output_function_sequencer
  import ofs_pkg::*;
#(
  parameter int TICK_CYCLES = `OFS_TICK_CYCLES
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // classic wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // input terminals and motor core
  input  wire logic [6:0]  term_in_i,
  input  wire logic        run_i,
  input  wire logic        dir_rev_i,
  input  wire logic [15:0] out_freq_i,
  input  wire logic [15:0] motor_current_i,
  input  wire logic [15:0] voltage_analog_input_i,
  input  wire logic [15:0] current_analog_input_i,
  input  wire logic [15:0] pulse_analog_input_i,
  // outputs
  output logic             relay_o,
  output logic             oc_out_o,
  output logic [15:0]      freq_target_o,
  output logic             freq_limit_o,
  output logic             freq_hold_o,
  output logic             freq_zero_o,
  output logic             dc_brake_o,
  output logic             out_block_o,
  output logic             start_dc_inhibit_o,
  output logic             dwell_inhibit_o
);

  // ----------
  // helpers
  // ----------
  // byte-lane merge on the low half word
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    wr16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : wr16

  // picks one source per output code
  function automatic logic pick_src(input logic [5:0] code, input logic tmr,
                                    input logic brk, input logic cmp);
    pick_src = (code == `OFS_FN_TIMER_OUT) ? tmr :
               (code == `OFS_FN_BRAKE)     ? brk :
               (code == `OFS_FN_ONOFF)     ? cmp : 1'b0;
  endfunction : pick_src

  // ----------
  // configuration registers
  // ----------
  logic [5:0]    relay_func_reg;
  logic [5:0]    open_collector_output_function_reg;
  logic [15:0]   tmr_on_reg;
  logic [15:0]   tmr_off_reg;
  logic          brk_en_reg;
  logic [15:0]   release_current_level_reg;
  logic [15:0]   release_hold_time_reg;
  logic [15:0]   release_freq_forward_reg;
  logic [15:0]   release_freq_reverse_reg;
  logic [15:0]   engage_hold_time_reg;
  logic [15:0]   engage_frequency_reg;
  logic [15:0]   dc_time_reg;
  logic [15:0]   dc_level_reg;
  logic [1:0]    cmp_src_reg;
  logic [15:0]   cmp_on_reg;
  logic [15:0]   cmp_off_reg;
  logic [5:0]    input_terminal_function_reg [7];
  logic          ack_reg;

  // bus decode
  wire           bus_req = cyc_i & stb_i & ~ack_reg;
  wire           wr_en   = bus_req & we_i;
  wire  [15:0]   on_wr   = wr16(cmp_on_reg, dat_i, sel_i);
  wire  [15:0]   off_wr  = wr16(cmp_off_reg, dat_i, sel_i);
  // clamp thresholds against each other and full scale
  wire  [15:0]   on_lim  = (on_wr > `OFS_FULL_SCALE) ? `OFS_FULL_SCALE : on_wr;
  wire  [15:0]   on_next = (on_lim < cmp_off_reg) ? cmp_off_reg : on_lim;
  wire  [15:0]   off_next = (off_wr > cmp_on_reg) ? cmp_on_reg : off_wr;

  // register writes, one access per acknowledged cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      relay_func_reg                     <= 6'h00;
      open_collector_output_function_reg <= 6'h00;
      tmr_on_reg                         <= `OFS_RST_TMR_ON;
      tmr_off_reg                        <= `OFS_RST_TMR_OFF;
      brk_en_reg                         <= 1'b0;
      release_current_level_reg          <= `OFS_RST_REL_CURR;
      release_hold_time_reg              <= `OFS_RST_REL_HOLD;
      release_freq_forward_reg           <= `OFS_RST_REL_FREQ;
      release_freq_reverse_reg           <= `OFS_RST_REL_FREQ;
      engage_hold_time_reg               <= `OFS_RST_ENG_HOLD;
      engage_frequency_reg               <= `OFS_RST_ENG_FREQ;
      dc_time_reg                        <= 16'h0000;
      dc_level_reg                       <= 16'h0000;
      cmp_src_reg                        <= `OFS_RST_CMP_SRC;
      cmp_on_reg                         <= `OFS_RST_CMP_ON;
      cmp_off_reg                        <= `OFS_RST_CMP_OFF;
      for (int i = 0; i < 7; i++)
        input_terminal_function_reg[i] <= 6'h00;
    end
    else if (wr_en)
    begin
      unique case (adr_i)
        `OFS_A_RELAY_FUNC: if (sel_i[0]) relay_func_reg <= dat_i[5:0];
        `OFS_A_OC_FUNC:    if (sel_i[0]) open_collector_output_function_reg <= dat_i[5:0];
        `OFS_A_TMR_ON:     tmr_on_reg <= wr16(tmr_on_reg, dat_i, sel_i);
        `OFS_A_TMR_OFF:    tmr_off_reg <= wr16(tmr_off_reg, dat_i, sel_i);
        `OFS_A_BRK_EN:     if (sel_i[0]) brk_en_reg <= dat_i[0];
        `OFS_A_REL_CURR:   release_current_level_reg <= wr16(release_current_level_reg, dat_i, sel_i);
        `OFS_A_REL_HOLD:   release_hold_time_reg <= wr16(release_hold_time_reg, dat_i, sel_i);
        `OFS_A_REL_FWD:    release_freq_forward_reg <= wr16(release_freq_forward_reg, dat_i, sel_i);
        `OFS_A_REL_REV:    release_freq_reverse_reg <= wr16(release_freq_reverse_reg, dat_i, sel_i);
        `OFS_A_ENG_HOLD:   engage_hold_time_reg <= wr16(engage_hold_time_reg, dat_i, sel_i);
        `OFS_A_ENG_FREQ:   engage_frequency_reg <= wr16(engage_frequency_reg, dat_i, sel_i);
        `OFS_A_DC_TIME:    dc_time_reg <= wr16(dc_time_reg, dat_i, sel_i);
        `OFS_A_DC_LEVEL:   dc_level_reg <= wr16(dc_level_reg, dat_i, sel_i);
        `OFS_A_CMP_SRC:    if (sel_i[0]) cmp_src_reg <= dat_i[1:0];
        `OFS_A_CMP_ON:     cmp_on_reg <= on_next;
        `OFS_A_CMP_OFF:    cmp_off_reg <= off_next;
        default:
        begin
          // terminal function codes sit at consecutive words
          for (int i = 0; i < 7; i++)
            if (adr_i == `OFS_A_IN_FUNC0 + 8'(4 * i) && sel_i[0])
              input_terminal_function_reg[i] <= dat_i[5:0];
        end
      endcase
    end
  end

  // ----------
  // 10 ms tick divider
  // ----------
  logic [31:0]   tick_cnt_reg;
  wire           tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tick_cnt_reg <= 32'h0000_0000;
    else
      tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
  end

  // ----------
  // on/off delay timer
  // ----------
  logic [6:0]    trig_vec;
  logic          tmr_out_reg;
  logic [15:0]   tmr_cnt_reg;

  // any terminal coded as timer input triggers it
  always_comb
  begin
    for (int i = 0; i < 7; i++)
      trig_vec[i] = term_in_i[i] & (input_terminal_function_reg[i] == `OFS_FN_TIMER_IN);
  end

  wire           tmr_trig    = |trig_vec;
  wire           tmr_pending = tmr_trig ^ tmr_out_reg;
  wire  [15:0]   tmr_limit   = tmr_trig ? tmr_on_reg : tmr_off_reg;

  // counter restarts whenever the trigger returns to the output's level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tmr_out_reg <= 1'b0;
      tmr_cnt_reg <= 16'h0000;
    end
    else if (!tmr_pending)
      tmr_cnt_reg <= 16'h0000;
    else if (tmr_cnt_reg > tmr_limit)
    begin
      tmr_out_reg <= tmr_trig;
      tmr_cnt_reg <= 16'h0000;
    end
    else if (tick)
      tmr_cnt_reg <= tmr_cnt_reg + 16'h0001;
  end

  // ----------
  // brake release / engage sequencer
  // ----------
  ofs_brake_st_t st_reg;
  ofs_brake_st_t st_next;
  logic          brk_rel_reg;
  logic [15:0]   brk_cnt_reg;
  logic [15:0]   rel_freq_reg;

  wire  [15:0]   rel_freq   = dir_rev_i ? release_freq_reverse_reg : release_freq_forward_reg;
  wire           dc_wanted  = (dc_time_reg != 16'h0000) && (dc_level_reg != 16'h0000);
  // first tick is partial, so a full delay needs one count beyond it
  wire           rhold_done = brk_cnt_reg > release_hold_time_reg;
  wire           ehold_done = brk_cnt_reg > engage_hold_time_reg;
  wire           dc_done    = brk_cnt_reg > dc_time_reg;

  // next state; a dropped run before release simply returns to stop
  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg)
      OFS_ST_IDLE,
      OFS_ST_BLOCK: if (brk_en_reg && run_i) st_next = OFS_ST_ACCEL;
      OFS_ST_ACCEL: if (!run_i) st_next = OFS_ST_IDLE;
                    else if (out_freq_i >= rel_freq_reg) st_next = OFS_ST_CURR;
      OFS_ST_CURR:  if (!run_i) st_next = OFS_ST_IDLE;
                    else if (motor_current_i >= release_current_level_reg)
                      st_next = OFS_ST_RHOLD;
      OFS_ST_RHOLD: if (rhold_done) st_next = OFS_ST_RUN;
      OFS_ST_RUN:   if (!run_i) st_next = OFS_ST_DECEL;
      OFS_ST_DECEL: if (out_freq_i <= engage_frequency_reg) st_next = OFS_ST_EHOLD;
      OFS_ST_EHOLD: if (ehold_done) st_next = dc_wanted ? OFS_ST_DC : OFS_ST_IDLE;
      OFS_ST_DC:    if (dc_done) st_next = OFS_ST_BLOCK;
      default:      st_next = OFS_ST_IDLE;
    endcase
  end

  // state, hold counter, brake release level and latched release frequency
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg       <= OFS_ST_IDLE;
      brk_rel_reg  <= 1'b0;
      brk_cnt_reg  <= 16'h0000;
      rel_freq_reg <= 16'h0000;
    end
    else
    begin
      st_reg <= brk_en_reg ? st_next : OFS_ST_IDLE;
      if (st_next != st_reg)
        brk_cnt_reg <= 16'h0000;
      else if (tick)
        brk_cnt_reg <= brk_cnt_reg + 16'h0001;
      if (st_reg == OFS_ST_IDLE || st_reg == OFS_ST_BLOCK)
        rel_freq_reg <= rel_freq;
      if (!brk_en_reg || st_next == OFS_ST_EHOLD || st_next == OFS_ST_IDLE)
        brk_rel_reg <= 1'b0;
      else if (st_next == OFS_ST_RHOLD)
        brk_rel_reg <= 1'b1;
    end
  end

  // speed, braking and inhibit commands to the motor core
  assign freq_target_o      = rel_freq_reg;
  assign freq_limit_o       = st_reg == OFS_ST_ACCEL;
  assign freq_hold_o        = st_reg == OFS_ST_CURR || st_reg == OFS_ST_RHOLD ||
                              st_reg == OFS_ST_EHOLD;
  assign freq_zero_o        = brk_en_reg && (st_reg == OFS_ST_IDLE || st_reg == OFS_ST_DC ||
                              st_reg == OFS_ST_BLOCK);
  assign dc_brake_o         = st_reg == OFS_ST_DC;
  assign out_block_o        = st_reg == OFS_ST_BLOCK;
  assign start_dc_inhibit_o = brk_en_reg;
  assign dwell_inhibit_o    = brk_en_reg;

  // ----------
  // analog on/off comparator
  // ----------
  logic          cmp_out_reg;
  wire  [15:0]   cmp_val = (cmp_src_reg == 2'h1) ? voltage_analog_input_i :
                           (cmp_src_reg == 2'h2) ? current_analog_input_i :
                           (cmp_src_reg == 2'h3) ? pulse_analog_input_i : 16'h0000;

  // band between the levels keeps the last state, so noise cannot chatter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cmp_out_reg <= 1'b0;
    else if (cmp_val >= cmp_on_reg)
      cmp_out_reg <= 1'b1;
    else if (cmp_val <= cmp_off_reg)
      cmp_out_reg <= 1'b0;
  end

  // ----------
  // output selection
  // ----------
  logic          relay_reg;
  logic          oc_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      relay_reg <= 1'b0;
      oc_reg    <= 1'b0;
    end
    else
    begin
      relay_reg <= pick_src(relay_func_reg, tmr_out_reg, brk_rel_reg, cmp_out_reg);
      oc_reg    <= pick_src(open_collector_output_function_reg, tmr_out_reg, brk_rel_reg,
                            cmp_out_reg);
    end
  end

  assign relay_o  = relay_reg;
  assign oc_out_o = oc_reg;

  // ----------
  // read mux and acknowledge
  // ----------
  logic [31:0]   rd_mux;
  logic [31:0]   dat_reg;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (adr_i)
      `OFS_A_RELAY_FUNC: rd_mux = {26'h0, relay_func_reg};
      `OFS_A_OC_FUNC:    rd_mux = {26'h0, open_collector_output_function_reg};
      `OFS_A_TMR_ON:     rd_mux = {16'h0, tmr_on_reg};
      `OFS_A_TMR_OFF:    rd_mux = {16'h0, tmr_off_reg};
      `OFS_A_BRK_EN:     rd_mux = {31'h0, brk_en_reg};
      `OFS_A_REL_CURR:   rd_mux = {16'h0, release_current_level_reg};
      `OFS_A_REL_HOLD:   rd_mux = {16'h0, release_hold_time_reg};
      `OFS_A_REL_FWD:    rd_mux = {16'h0, release_freq_forward_reg};
      `OFS_A_REL_REV:    rd_mux = {16'h0, release_freq_reverse_reg};
      `OFS_A_ENG_HOLD:   rd_mux = {16'h0, engage_hold_time_reg};
      `OFS_A_ENG_FREQ:   rd_mux = {16'h0, engage_frequency_reg};
      `OFS_A_DC_TIME:    rd_mux = {16'h0, dc_time_reg};
      `OFS_A_DC_LEVEL:   rd_mux = {16'h0, dc_level_reg};
      `OFS_A_CMP_SRC:    rd_mux = {30'h0, cmp_src_reg};
      `OFS_A_CMP_ON:     rd_mux = {16'h0, cmp_on_reg};
      `OFS_A_CMP_OFF:    rd_mux = {16'h0, cmp_off_reg};
      `OFS_A_STATUS:     rd_mux = {7'h0, st_reg, 11'h0, relay_reg, oc_reg, cmp_out_reg,
                                   brk_rel_reg, tmr_out_reg};
      default:
      begin
        for (int i = 0; i < 7; i++)
          if (adr_i == `OFS_A_IN_FUNC0 + 8'(4 * i))
            rd_mux = {26'h0, input_terminal_function_reg[i]};
      end
    endcase
  end

  // ack one cycle after the request; unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= bus_req;
      if (bus_req && !we_i)
        dat_reg <= rd_mux;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

endmodule : ofs_output_function_sequencer

`default_nettype wire

// file: ofs_output_function_sequencer_checker.sv
// port-level assertions for the output function sequencer
`include "ofs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ofs_output_function_sequencer_checker #(
  parameter int TICK_CYCLES = 4
)(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        run_i,
  input wire logic [15:0] out_freq_i,
  input wire logic [15:0] freq_target_o,
  input wire logic        freq_limit_o,
  input wire logic        freq_hold_o,
  input wire logic        freq_zero_o,
  input wire logic        dc_brake_o,
  input wire logic        out_block_o,
  input wire logic        start_dc_inhibit_o,
  input wire logic        dwell_inhibit_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------
  // bus handshake
  // ----------
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack after request");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack wider than one cycle");
  chk_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  chk_unmapped_zero: assert property (cyc_i && stb_i && !ack_o && !we_i && adr_i == 8'hFC
    |=> dat_o == 32'h00000000) else $error("unmapped read not zero");
  // ----------
  // brake sequencer
  // ----------
  chk_inhibit_pair: assert property (start_dc_inhibit_o == dwell_inhibit_o)
    else $error("inhibit outputs disagree");
  chk_zero_brake: assert property (freq_zero_o |-> start_dc_inhibit_o)
    else $error("zero frequency without brake control");
  chk_release_wait: assert property ($fell(freq_limit_o) && $past(run_i) && !$past(rst_i)
    |-> freq_hold_o && $past(out_freq_i) >= $past(freq_target_o))
    else $error("ramp left before release frequency");
  chk_hold_excl: assert property (freq_hold_o |-> !freq_limit_o && !out_block_o)
    else $error("hold together with ramp or block");
  chk_engage_stop: assert property ($rose(freq_hold_o) && !$past(run_i) && !$past(rst_i)
    |-> $past(out_freq_i) <= `OFS_RST_ENG_FREQ) else $error("engage hold above level");
  chk_block_zero: assert property (out_block_o |-> freq_zero_o && !dc_brake_o)
    else $error("block without zero frequency");
  chk_dc_block: assert property ($fell(dc_brake_o) && !$past(rst_i) |-> out_block_o)
    else $error("dc braking ended without block");
  // main scenarios reached
  cov_release: cover property ($rose(freq_hold_o) && run_i);
  cov_engage: cover property ($rose(freq_hold_o) && !run_i);
  cov_block: cover property ($rose(out_block_o));
endmodule : ofs_output_function_sequencer_checker

bind ofs_output_function_sequencer ofs_output_function_sequencer_checker
  #(.TICK_CYCLES(TICK_CYCLES)) i_ofs_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .dat_o, .ack_o, .run_i, .out_freq_i, .freq_target_o, .freq_limit_o,
  .freq_hold_o, .freq_zero_o, .dc_brake_o, .out_block_o, .start_dc_inhibit_o,
  .dwell_inhibit_o);
`default_nettype wire

// file: ofs_pkg.sv
// types for the output function sequencer
package ofs_pkg;
  // brake sequencer states, one-hot
  typedef enum logic [8:0] {
    OFS_ST_IDLE  = 9'h001,
    OFS_ST_ACCEL = 9'h002,
    OFS_ST_CURR  = 9'h004,
    OFS_ST_RHOLD = 9'h008,
    OFS_ST_RUN   = 9'h010,
    OFS_ST_DECEL = 9'h020,
    OFS_ST_EHOLD = 9'h040,
    OFS_ST_DC    = 9'h080,
    OFS_ST_BLOCK = 9'h100
  } ofs_brake_st_t;
endpackage : ofs_pkg

// file: tb_output_function_sequencer.sv
// self-checking bench for the output function sequencer
`include "ofs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_output_function_sequencer;
  localparam int TICK = 4;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, run_i, dir_rev_i, ack_o, relay_o;
  logic        oc_out_o, freq_limit_o, freq_hold_o, freq_zero_o, dc_brake_o;
  logic        out_block_o, start_dc_inhibit_o, dwell_inhibit_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [6:0]  term_in_i;
  logic [15:0] out_freq_i, motor_current_i, volt_i, curr_i, load, freq_target_o;
  int          fails = 0, checks_done = 0, cycles = 0, n;
  logic [7:0]  ra [11] = '{`OFS_A_TMR_ON, `OFS_A_TMR_OFF, `OFS_A_REL_CURR,
    `OFS_A_REL_HOLD, `OFS_A_REL_FWD, `OFS_A_REL_REV, `OFS_A_ENG_HOLD,
    `OFS_A_ENG_FREQ, `OFS_A_CMP_SRC, `OFS_A_CMP_ON, `OFS_A_CMP_OFF};
  logic [15:0] rv [11] = '{`OFS_RST_TMR_ON, `OFS_RST_TMR_OFF, `OFS_RST_REL_CURR,
    `OFS_RST_REL_HOLD, `OFS_RST_REL_FREQ, `OFS_RST_REL_FREQ, `OFS_RST_ENG_HOLD,
    `OFS_RST_ENG_FREQ, 16'h0001, `OFS_RST_CMP_ON, `OFS_RST_CMP_OFF};

  ofs_output_function_sequencer #(.TICK_CYCLES(TICK)) i_ofs_output_function_sequencer (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .term_in_i, .run_i, .dir_rev_i, .out_freq_i, .motor_current_i,
    .voltage_analog_input_i(volt_i), .current_analog_input_i(curr_i),
    .pulse_analog_input_i(16'h0000), .relay_o, .oc_out_o, .freq_target_o, .freq_limit_o,
    .freq_hold_o, .freq_zero_o, .dc_brake_o, .out_block_o, .start_dc_inhibit_o,
    .dwell_inhibit_o);
  ofs_motor_model i_ofs_motor_model (.clk_i, .rst_i, .run_i, .freq_target_i(freq_target_o),
    .freq_limit_i(freq_limit_o), .freq_hold_i(freq_hold_o), .freq_zero_i(freq_zero_o),
    .load_i(load), .out_freq_o(out_freq_i), .current_o(motor_current_i));
  // ----------
  // clock, watchdog, helpers
  // ----------
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // a hung handshake ends here; wait_lvl gives up by itself after 300 edges
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // request held until ack is sampled high, released at that edge
  task automatic wb(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, wr, a, 16'h0000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask : wb
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic check_rng(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_rng
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
    wb(1'b0, a, 16'h0000);
    check(what, exp, rd[15:0]);
  endtask : rd_chk
  function automatic logic pick(input int s);
    case (s)
      0: return relay_o;
      1: return oc_out_o;
      3: return freq_hold_o;
      default: return out_block_o;
    endcase
  endfunction : pick
  // n counts the edges until the chosen output shows the level
  task automatic wait_lvl(input int s, input logic lvl);
    n = 0;
    while (pick(s) !== lvl && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_lvl
  // ----------
  // main sequence
  // ----------
  initial
  begin
    {cyc_i, stb_i, we_i, run_i, dir_rev_i, adr_i, sel_i, dat_i} = '0;
    {term_in_i, volt_i, curr_i, load} = '0;
    sel_i = 4'hF;
    rst_i = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 11; i++)
      rd_chk("reset value", ra[i], rv[i]);
    wb(1'b1, 8'hFC, 16'hFFFF);
    rd_chk("unmapped", 8'hFC, 16'h0000);
    // threshold ordering kept on every write
    wb(1'b1, `OFS_A_CMP_ON, 16'h01F4);
    rd_chk("on below off", `OFS_A_CMP_ON, 16'h03E8);
    wb(1'b1, `OFS_A_CMP_ON, 16'h2EE0);
    rd_chk("on above full", `OFS_A_CMP_ON, `OFS_FULL_SCALE);
    wb(1'b1, `OFS_A_CMP_OFF, 16'h2AF8);
    rd_chk("off above on", `OFS_A_CMP_OFF, `OFS_FULL_SCALE);
    wb(1'b1, `OFS_A_CMP_OFF, 16'h03E8);
    wb(1'b1, `OFS_A_CMP_ON, 16'h2328);
    // timer on terminal 2, relay follows it
    wb(1'b1, `OFS_A_IN_FUNC0 + 8'h08, {10'h000, `OFS_FN_TIMER_IN});
    wb(1'b1, `OFS_A_RELAY_FUNC, {10'h000, `OFS_FN_TIMER_OUT});
    wb(1'b1, `OFS_A_TMR_ON, 16'h0003);
    wb(1'b1, `OFS_A_TMR_OFF, 16'h0002);
    term_in_i <= 7'h02;
    repeat (6 * TICK) @(posedge clk_i);
    check("other terminal", 16'h0000, relay_o);
    term_in_i <= 7'h04;
    repeat (2 * TICK) @(posedge clk_i);
    term_in_i <= 7'h00;
    repeat (6 * TICK) @(posedge clk_i);
    check("short trigger", 16'h0000, relay_o);
    term_in_i <= 7'h04;
    wait_lvl(0, 1'b1);
    check_rng("on delay", 3 * TICK, 5 * TICK, n);
    check("oc unselected", 16'h0000, oc_out_o);
    term_in_i <= 7'h00;
    wait_lvl(0, 1'b0);
    check_rng("off delay", 2 * TICK, 4 * TICK, n);
    // comparator drives the open-collector output
    wb(1'b1, `OFS_A_OC_FUNC, {10'h000, `OFS_FN_ONOFF});
    volt_i <= 16'h2327;
    repeat (5) @(posedge clk_i);
    check("below on level", 16'h0000, oc_out_o);
    volt_i <= 16'h2328;
    wait_lvl(1, 1'b1);
    check("at on level", 16'h0001, oc_out_o);
    volt_i <= 16'h1388;
    repeat (5) @(posedge clk_i);
    check("between levels", 16'h0001, oc_out_o);
    volt_i <= 16'h03E8;
    wait_lvl(1, 1'b0);
    check("at off level", 16'h0000, oc_out_o);
    wb(1'b1, `OFS_A_CMP_SRC, 16'h0002);
    curr_i <= 16'h2710;
    wait_lvl(1, 1'b1);
    check("current source", 16'h0001, oc_out_o);
    // brake sequence in reverse, with dc braking at the end
    wb(1'b1, `OFS_A_RELAY_FUNC, {10'h000, `OFS_FN_BRAKE});
    wb(1'b1, `OFS_A_REL_REV, 16'h012C);
    wb(1'b1, `OFS_A_REL_HOLD, 16'h0002);
    wb(1'b1, `OFS_A_ENG_HOLD, 16'h0002);
    wb(1'b1, `OFS_A_DC_TIME, 16'h0002);
    wb(1'b1, `OFS_A_DC_LEVEL, 16'h0032);
    wb(1'b1, `OFS_A_BRK_EN, 16'h0001);
    repeat (2) @(posedge clk_i);
    check("start dc inhibit", 16'h0003, {start_dc_inhibit_o, dwell_inhibit_o});
    {dir_rev_i, run_i} <= 2'b11;
    wait_lvl(3, 1'b1);
    check("reverse target", 16'h012C, freq_target_o);
    check("ramp reached", 16'h012C, out_freq_i);
    repeat (5) @(posedge clk_i);
    check("no current", 16'h0000, relay_o);
    load <= 16'h01F4;
    wait_lvl(0, 1'b1);
    check_rng("release", 0, 3, n);
    wait_lvl(3, 1'b0);
    check_rng("release hold", 2 * TICK - 2, 3 * TICK + 1, n);
    repeat (20) @(posedge clk_i);
    check("accelerating", 16'h0001, out_freq_i > 16'h012C);
    run_i <= 1'b0;
    wait_lvl(3, 1'b1);
    check("engage level", 16'h0001, out_freq_i >= 16'h00BE && out_freq_i <= 16'h00C8);
    wait_lvl(0, 1'b0);
    check_rng("engage signal", 0, 3, n);
    wait_lvl(4, 1'b1);
    check("zero then block", 16'h0002, {freq_zero_o, dc_brake_o});
    stop_test();
  end
endmodule : tb_output_function_sequencer
`default_nettype wire
